// ===== rtl/fprc_ctrl.v
// Function
// RULE_01: The device holds 2048 words of 8 bits, every address one word.
// RULE_02: Bits read zero unprogrammed and a programmed one stays one.
// RULE_03: The same address pins select the word for reads and programming.
// RULE_04: To read, drive the active-low select low and both highs high.
// RULE_05: While enabled the device drives the addressed word on its outputs.
// RULE_06: Programming first drives all eleven address pins to the word.
// RULE_07: Before pulsing, the device is disabled through a chip select.
// RULE_08: Pulse the bit's output, sensing between pulses until it reads one. The code stops after MAX_PULSE pulses and flags o_pg_fail.
// RULE_09: After the bit senses one, give one more pulse and then stop.
// RULE_10: With any select inactive the device releases its outputs.
`timescale 1ns/1ps
`default_nettype none
`include "fprc_defs.vh"
module fprc_ctrl #(
    parameter AW        = `FPRC_ADDR_W,
    parameter DW        = `FPRC_DATA_W,
    parameter SETUP_CYC = `FPRC_ADDR_SETUP_CYC,
    parameter HOLD_CYC  = `FPRC_ADDR_HOLD_CYC,
    parameter PULSE_CYC = `FPRC_PULSE_CYC,
    parameter SSU_CYC   = `FPRC_SENSE_SU_CYC,
    parameter SHD_CYC   = `FPRC_SENSE_HD_CYC,
    parameter ACC_CYC   = `FPRC_ACCESS_CYC,
    parameter MAX_PULSE = `FPRC_MAX_PULSES
) (
    input  wire          i_sys_clk,          // System clock
    input  wire          i_rst,              // Async reset, active high
    input  wire          i_rd_req,           // Read request pulse
    input  wire          i_pg_req,           // Program request pulse
    input  wire [AW-1:0] i_addr,             // Word address
    input  wire [DW-1:0] i_pg_data,          // Ones to program
    output wire          o_ready,            // Idle, accepts a request
    output reg  [DW-1:0] o_rd_data,          // Read word
    output reg           o_rd_valid,         // Read data valid pulse
    output reg           o_pg_done,          // Programming done pulse
    output reg           o_pg_fail,          // A bit never sensed one
    output reg  [AW-1:0] o_prom_addr,        // Device address pins
    output reg           o_select_active_low,// Active-low chip select
    output reg           o_select_high_b,    // Active-high chip select
    output reg           o_select_high_c,    // Active-high chip select
    input  wire [DW-1:0] i_prom_data,        // Device data outputs
    output reg  [DW-1:0] o_pulse,            // Programming pulse per bit
    output reg  [DW-1:0] o_sense             // Sense current per bit
);
    localparam ST_IDLE  = 3'h0;
    localparam ST_RACC  = 3'h1;
    localparam ST_SETUP = 3'h2;
    localparam ST_PULSE = 3'h3;
    localparam ST_SSU   = 3'h4;
    localparam ST_SHD   = 3'h5;
    localparam ST_HOLD  = 3'h6;
    localparam TW = 16;

    reg [2:0]    state_ff;
    reg [DW-1:0] todo_ff;
    reg [2:0]    bit_ff;
    reg          extra_ff;
    reg [TW-1:0] npulse_ff;
    reg          fail_ff;
    reg [DW-1:0] din_s1_ff;
    reg [DW-1:0] din_s2_ff;
    reg          tm_load;
    reg [TW-1:0] tm_count;
    wire         tm_done;

    fprc_timer #(.W(TW)) u_timer (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_load    (tm_load),
        .i_count   (tm_count),
        .o_done    (tm_done)
    );

    function [2:0] low_bit;
        input [DW-1:0] v;
        integer k;
        begin
            low_bit = 3'h0;
            for (k = DW - 1; k >= 0; k = k - 1)
                if (v[k])
                    low_bit = k[2:0];
        end
    endfunction

    function [TW-1:0] cyc;
        input integer n;
        begin
            cyc = n[TW-1:0];
        end
    endfunction

    assign o_ready = (state_ff == ST_IDLE);

    // Device outputs are asynchronous to our clock
    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            din_s1_ff <= {DW{1'b0}};
            din_s2_ff <= {DW{1'b0}};
        end
        else
        begin
            din_s1_ff <= i_prom_data;
            din_s2_ff <= din_s1_ff;
        end
    end

    always @*
    begin
        tm_load  = 1'b0;
        tm_count = {TW{1'b0}};
        case (state_ff)
            ST_IDLE:
            begin
                tm_load  = i_rd_req || (i_pg_req && i_pg_data != {DW{1'b0}});
                tm_count = i_rd_req ? cyc(ACC_CYC + 2) : cyc(SETUP_CYC);
            end
            ST_SETUP, ST_SHD:
            begin
                tm_load  = tm_done;
                tm_count = cyc(PULSE_CYC);
            end
            ST_PULSE:
            begin
                tm_load  = tm_done;
                tm_count = cyc(SSU_CYC + 2);
            end
            ST_SSU:
            begin
                tm_load  = tm_done;
                tm_count = (extra_ff || npulse_ff >= cyc(MAX_PULSE)) ?
                           cyc(HOLD_CYC) : cyc(SHD_CYC);
            end
            default:
            begin
                tm_load  = 1'b0;
                tm_count = {TW{1'b0}};
            end
        endcase
    end

    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_ff            <= ST_IDLE;
            todo_ff             <= {DW{1'b0}};
            bit_ff              <= 3'h0;
            extra_ff            <= 1'b0;
            npulse_ff           <= {TW{1'b0}};
            fail_ff             <= 1'b0;
            o_rd_data           <= {DW{1'b0}};
            o_rd_valid          <= 1'b0;
            o_pg_done           <= 1'b0;
            o_pg_fail           <= 1'b0;
            o_prom_addr         <= {AW{1'b0}};
            o_select_active_low <= 1'b1;
            o_select_high_b     <= 1'b0;
            o_select_high_c     <= 1'b0;
            o_pulse             <= {DW{1'b0}};
            o_sense             <= {DW{1'b0}};
        end
        else
        begin
            o_rd_valid <= 1'b0;
            o_pg_done  <= 1'b0;
            case (state_ff)
                ST_IDLE:
                    if (i_rd_req)
                    begin
                        o_prom_addr         <= i_addr;       // [RULE_03]
                        o_select_active_low <= 1'b0;         // [RULE_04]
                        o_select_high_b     <= 1'b1;         // [RULE_04]
                        o_select_high_c     <= 1'b1;         // [RULE_04]
                        state_ff            <= ST_RACC;
                    end
                    else if (i_pg_req)
                    begin
                        // Only ones are programmed; zeros need nothing
                        todo_ff             <= i_pg_data;    // [RULE_02]
                        bit_ff              <= low_bit(i_pg_data);
                        extra_ff            <= 1'b0;
                        npulse_ff           <= {TW{1'b0}};
                        fail_ff             <= 1'b0;
                        o_prom_addr         <= i_addr;       // [RULE_06]
                        o_select_active_low <= 1'b1;         // [RULE_07]
                        o_select_high_b     <= 1'b0;         // [RULE_07]
                        o_select_high_c     <= 1'b0;         // [RULE_07]
                        if (i_pg_data == {DW{1'b0}})
                        begin
                            o_pg_done <= 1'b1;
                            o_pg_fail <= 1'b0;
                        end
                        else
                            state_ff <= ST_SETUP;
                    end
                ST_RACC:
                    if (tm_done)
                    begin
                        // Access time plus synchroniser delay
                        o_rd_data           <= din_s2_ff;    // [RULE_05]
                        o_rd_valid          <= 1'b1;
                        o_select_active_low <= 1'b1;         // [RULE_10]
                        o_select_high_b     <= 1'b0;
                        o_select_high_c     <= 1'b0;
                        state_ff            <= ST_IDLE;
                    end
                ST_SETUP, ST_SHD:
                    if (tm_done)
                    begin
                        o_sense   <= {DW{1'b0}};
                        o_pulse   <= {{(DW-1){1'b0}}, 1'b1} << bit_ff; // [RULE_08]
                        npulse_ff <= npulse_ff + {{(TW-1){1'b0}}, 1'b1};
                        state_ff  <= ST_PULSE;
                    end
                ST_PULSE:
                    if (tm_done)
                    begin
                        o_pulse  <= {DW{1'b0}};
                        o_sense  <= {{(DW-1){1'b0}}, 1'b1} << bit_ff; // [RULE_08]
                        state_ff <= ST_SSU;
                    end
                ST_SSU:
                    if (tm_done)
                    begin
                        if (extra_ff || npulse_ff >= cyc(MAX_PULSE))
                        begin
                            // Extra pulse given, or bit gave up: next bit
                            o_sense  <= {DW{1'b0}};
                            fail_ff  <= fail_ff | !extra_ff;
                            todo_ff  <= todo_ff & ~({{(DW-1){1'b0}}, 1'b1} << bit_ff); // [RULE_09]
                            state_ff <= ST_HOLD;
                        end
                        else
                        begin
                            if (din_s2_ff[bit_ff])
                                extra_ff <= 1'b1;            // [RULE_09]
                            state_ff <= ST_SHD;
                        end
                    end
                ST_HOLD:
                    if (tm_done)
                    begin
                        extra_ff  <= 1'b0;
                        npulse_ff <= {TW{1'b0}};
                        bit_ff    <= low_bit(todo_ff);
                        if (todo_ff == {DW{1'b0}})
                        begin
                            o_pg_done <= 1'b1;
                            o_pg_fail <= fail_ff;
                            state_ff  <= ST_IDLE;
                        end
                        else
                            state_ff <= ST_SETUP;
                    end
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== rtl/fprc_defs.vh
`ifndef FPRC_DEFS_VH
`define FPRC_DEFS_VH

`define FPRC_ADDR_W        11
`define FPRC_DATA_W        8
`define FPRC_CLK_NS        10
// Programming and read timing, in ns as specified; pulse limits as counts
`define FPRC_ADDR_SETUP_NS 10000
`define FPRC_ADDR_HOLD_NS  10000
`define FPRC_PULSE_NS      7500
`define FPRC_SENSE_SU_NS   700
`define FPRC_SENSE_HD_NS   700
`define FPRC_ACCESS_NS     60
`define FPRC_MAX_PULSES    10000
`define FPRC_EXTRA_PULSES  1
// Cycle counts: least times round up, longest times round down
`define FPRC_ADDR_SETUP_CYC ((`FPRC_ADDR_SETUP_NS + `FPRC_CLK_NS - 1) / `FPRC_CLK_NS)
`define FPRC_ADDR_HOLD_CYC  ((`FPRC_ADDR_HOLD_NS + `FPRC_CLK_NS - 1) / `FPRC_CLK_NS)
`define FPRC_PULSE_CYC      (`FPRC_PULSE_NS / `FPRC_CLK_NS)
`define FPRC_SENSE_SU_CYC   ((`FPRC_SENSE_SU_NS + `FPRC_CLK_NS - 1) / `FPRC_CLK_NS)
`define FPRC_SENSE_HD_CYC   ((`FPRC_SENSE_HD_NS + `FPRC_CLK_NS - 1) / `FPRC_CLK_NS)
`define FPRC_ACCESS_CYC     ((`FPRC_ACCESS_NS + `FPRC_CLK_NS - 1) / `FPRC_CLK_NS)

`endif

// ===== rtl/fprc_timer.v
`timescale 1ns/1ps
`default_nettype none
// Down counter used for every timed phase of the controller
module fprc_timer #(
    parameter W = 16
) (
    input  wire         i_sys_clk, // System clock
    input  wire         i_rst,     // Asynchronous reset, active high
    input  wire         i_load,    // Load a new count
    input  wire [W-1:0] i_count,   // Cycles to wait
    output wire         o_done     // Count has run out
);
    reg [W-1:0] cnt_ff;

    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            cnt_ff <= {W{1'b0}};
        else if (i_load)
            cnt_ff <= i_count;
        else if (cnt_ff != {W{1'b0}})
            cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
    end

    // Done must not look at the load: callers load on done, a loop otherwise
    assign o_done = (cnt_ff == {W{1'b0}});
endmodule
`default_nettype wire

// ===== sim/fprc_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module fprc_ctrl_props #(
    parameter ACC_CYC = 6
) (
    input wire logic        i_sys_clk,           // Clock
    input wire logic        i_rst,               // Reset
    input wire logic        i_rd_req,            // Read request
    input wire logic        i_pg_req,            // Program request
    input wire logic [10:0] i_addr,              // Address
    input wire logic [7:0]  i_pg_data,           // Ones to program
    input wire logic        o_ready,             // Idle
    input wire logic        o_rd_valid,          // Read done
    input wire logic        o_pg_done,           // Program done
    input wire logic [10:0] o_prom_addr,         // Address pins
    input wire logic        o_select_active_low, // Low select
    input wire logic        o_select_high_b,     // High select
    input wire logic        o_select_high_c,     // High select
    input wire logic [7:0]  o_pulse,             // Pulses
    input wire logic [7:0]  o_sense              // Sense enables
);
    localparam int RD_GAP = ACC_CYC + 3;
    wire en = !o_select_active_low && o_select_high_b && o_select_high_c;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    sequence s_rd_take;
        o_ready && i_rd_req;
    endsequence
    sequence s_pulse_on;
        // Bench count is five; a pulse stands one cycle beyond its count
        (|o_pulse) [*6] ##1 !(|o_pulse);
    endsequence
    a_idle_released: assert property (o_ready |-> !en)
        else $error("selects enabled while idle");
    a_pulse_disabled: assert property (|o_pulse |-> !en)
        else $error("pulse while device enabled");
    a_pulse_one_bit: assert property ($onehot0(o_pulse))
        else $error("more than one bit pulsed");
    a_sense_one_bit: assert property ($onehot0(o_sense))
        else $error("more than one bit sensed");
    a_pulse_sense_apart: assert property ((o_pulse & o_sense) == 8'h00)
        else $error("pulse and sense overlap");
    a_pulse_width: assert property ($rose(|o_pulse) |-> s_pulse_on)
        else $error("pulse width wrong");
    a_rd_latency: assert property (s_rd_take |-> ##1 !o_rd_valid ##RD_GAP o_rd_valid)
        else $error("read answer late or early");
    a_rd_addr_set: assert property (s_rd_take |=> o_prom_addr == $past(i_addr))
        else $error("read address not driven");
    a_rd_enable_win: assert property (s_rd_take |=> en [*8] ##1 en ##1 !en)
        else $error("read enable window wrong");
    a_pg_empty_done: assert property (o_ready && i_pg_req && !i_rd_req
        && i_pg_data == 8'h00 |=> o_pg_done)
        else $error("empty program not done");
    a_addr_held: assert property (|o_pulse |-> $stable(o_prom_addr))
        else $error("address moved under pulse");
endmodule
bind fprc_ctrl fprc_ctrl_props #(.ACC_CYC(ACC_CYC)) u_props (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_rd_req(i_rd_req),
    .i_pg_req(i_pg_req), .i_addr(i_addr), .i_pg_data(i_pg_data),
    .o_ready(o_ready), .o_rd_valid(o_rd_valid), .o_pg_done(o_pg_done),
    .o_prom_addr(o_prom_addr), .o_select_active_low(o_select_active_low),
    .o_select_high_b(o_select_high_b), .o_select_high_c(o_select_high_c),
    .o_pulse(o_pulse), .o_sense(o_sense));
`default_nettype wire

// ===== sim/fprc_prom_model.sv
`timescale 1ns/1ps
`default_nettype none
module fprc_prom_model #(
    parameter int FUSE_N = 3
) (
    input wire logic [10:0] i_addr,              // Address pins
    input wire logic        i_select_active_low, // Low select
    input wire logic        i_select_high_b,     // High select
    input wire logic        i_select_high_c,     // High select
    input wire logic [7:0]  i_pulse,             // Pulse per bit
    input wire logic [7:0]  i_sense,             // Sense per bit
    input wire logic [7:0]  i_dead,              // Fuses that never blow
    output logic     [7:0]  o_data               // Data outputs
);
    logic [7:0] mem [0:2047];
    wire en = !i_select_active_low && i_select_high_b && i_select_high_c;
    wire [7:0] vis = en ? 8'hFF : i_sense;
    initial foreach (mem[i]) mem[i] = 8'h00;
    // Released lines show the inverse so a stale sample is caught
    assign o_data = mem[i_addr] ^ ~vis;
    for (genvar b = 0; b < 8; b++)
    begin : g_bit
        int n = 0;
        always @(i_addr) n = 0;
        // Only ever sets a bit, never clears one
        always @(posedge i_pulse[b])
            if (!en && !i_dead[b])
            begin
                n = n + 1;
                if (n >= FUSE_N) mem[i_addr][b] = 1'b1;
            end
    end
endmodule
`default_nettype wire

// ===== sim/fprc_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fprc_ctrl_tb;
    logic clk = 0, rst = 1, rd = 0, pg = 0;
    logic [10:0] addr = 11'h000;
    logic [7:0] pdat = 8'h00, dead = 8'h00, npulse = 8'h00;
    logic prev = 0;
    int err_total = 0, n_compared = 0, cyc = 0;
    wire [10:0] pa;
    wire sal, sb, sc, rdy, rv, pd, pf;
    wire [7:0] rdat, pdq, pul, sen;
    fprc_ctrl #(.SETUP_CYC(10), .HOLD_CYC(10), .PULSE_CYC(5), .MAX_PULSE(8))
    DUT (.i_sys_clk(clk), .i_rst(rst), .i_rd_req(rd), .i_pg_req(pg),
        .i_addr(addr), .i_pg_data(pdat), .o_ready(rdy), .o_rd_data(rdat),
        .o_rd_valid(rv), .o_pg_done(pd), .o_pg_fail(pf), .o_prom_addr(pa),
        .o_select_active_low(sal), .o_select_high_b(sb),
        .o_select_high_c(sc), .i_prom_data(pdq), .o_pulse(pul),
        .o_sense(sen));
    fprc_prom_model #(.FUSE_N(3)) u_prom (.i_addr(pa),
        .i_select_active_low(sal), .i_select_high_b(sb),
        .i_select_high_c(sc), .i_pulse(pul), .i_sense(sen),
        .i_dead(dead), .o_data(pdq));
    initial forever #5 clk = ~clk;
    always @(posedge clk)
    begin
        prev <= |pul;
        if ((|pul) && !prev) npulse <= npulse + 8'h01;
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            err_total++;
            final_report();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rdw(input logic [10:0] a, input logic [7:0] exp);
        int k;
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        for (k = 0; k < 50 && rv !== 1'b1; k++) @(negedge clk);
        chk({7'h00, rv}, 8'h01);
        chk(rdat, exp);
        chk({7'h00, rdy}, 8'h01);
    endtask
    task automatic pgm(input logic [10:0] a, input logic [7:0] v);
        int k;
        @(negedge clk);
        addr = a;
        pdat = v;
        pg = 1'b1;
        npulse = 8'h00;
        @(negedge clk);
        pg = 1'b0;
        for (k = 0; k < 5000 && pd !== 1'b1; k++) @(negedge clk);
        chk({7'h00, pd}, 8'h01);
    endtask
    task automatic t_blank;
        rdw(11'h000, 8'h00);
        rdw(11'h7FF, 8'h00);
        rdw(11'h555, 8'h00);
    endtask
    task automatic t_single;
        pgm(11'h7FF, 8'h01);
        chk(npulse, 8'h04);
        chk({7'h00, pf}, 8'h00);
        rdw(11'h7FF, 8'h01);
        rdw(11'h7FE, 8'h00);
    endtask
    task automatic t_multi;
        pgm(11'h123, 8'hA5);
        rdw(11'h123, 8'hA5);
        pgm(11'h123, 8'h5A);
        rdw(11'h123, 8'hFF);
        pgm(11'h123, 8'h00);
        chk(npulse, 8'h00);
        rdw(11'h123, 8'hFF);
    endtask
    task automatic t_fail;
        dead = 8'h08;
        pgm(11'h010, 8'h08);
        chk({7'h00, pf}, 8'h01);
        chk(npulse, 8'h08);
        dead = 8'h00;
        rdw(11'h010, 8'h00);
    endtask
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        t_blank();
        t_fail();
        t_single();
        t_multi();
        final_report();
    end
endmodule
`default_nettype wire
